// *** pkg/dhi_cfg.svh ***
// Constants of the converter host-interface control block.
// Assumes inclusion by bare name from pkg/ on the include path.
`ifndef DHI_CFG_SVH
`define DHI_CFG_SVH

// Channel map
`define DHI_ADDR_W 5
`define DHI_NUM_CH 32
`define DHI_IDX_W 6
`define DHI_OFFSET_CH 6'h20
`define DHI_ALL_CH 6'h3F
`define DHI_CODE_W 14

// Serial word: read flag, channel address, code, sent MSB first
`define DHI_WORD_W 20
`define DHI_RD_BIT 19
`define DHI_WADDR_MSB 18
`define DHI_WADDR_LSB 14

// Pin levels assumed while the synchronisers are in reset
`define DHI_ADDR_RST 1'b1
`define DHI_TRACK_RST 1'b1
`define DHI_CAL_RST 1'b0
`define DHI_WR_RST 1'b0
`define DHI_CS_RST 1'b1
`define DHI_OSEL_RST 1'b0
`define DHI_IFSEL_RST 1'b0
`define DHI_SHM_RST 1'b0
`define DHI_CODE_RST 14'h0000

// Timing
`define DHI_CLK_NS 8
`define DHI_RST_MIN_NS 90
`define DHI_RST_MAX_NS 200
`define DHI_RST_MIN_CYC ((`DHI_RST_MIN_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS)
`define DHI_RST_MAX_CYC (`DHI_RST_MAX_NS / `DHI_CLK_NS)
`define DHI_ACQ_NS 1000
`define DHI_ACQ_CYC ((`DHI_ACQ_NS + `DHI_CLK_NS - 1) / `DHI_CLK_NS)

`endif

// *** pkg/dhi_pkg.sv ***
// Types of the converter host-interface control block.
// Assumes dhi_cfg.svh sits beside it on the include path.
`include "dhi_cfg.svh"
package dhi_pkg;
  typedef enum logic {DHI_IDLE, DHI_ACQUIRE} dhi_acq_state_type;
  typedef logic [`DHI_IDX_W-1:0] dhi_idx_type;
endpackage

// *** src/dhi_serial_link.sv ***
// Serial link end: word shift-in on falling clock, readback on rising clock.
// Assumes rb_word_in is held stable by the core while rb_toggle_in is pending.
`timescale 1ns/10ps
`include "dhi_cfg.svh"
module dhi_serial_link #(
  parameter int WORD_W = `DHI_WORD_W,
  parameter int CODE_W = `DHI_CODE_W
)(
  input wire logic sclk_in,
  input wire logic rst_in,
  input wire logic sync_n_in,
  input wire logic din_in,
  input wire logic [CODE_W-1:0] rb_word_in,
  input wire logic rb_toggle_in,
  output logic [WORD_W-1:0] word_out,
  output logic word_toggle_out,
  output logic dout_out
);
  localparam logic [4:0] LAST_BIT = 5'(WORD_W - 1);
  localparam logic [4:0] DONE_CNT = 5'(WORD_W);

  logic frame_clr;
  logic [4:0] bit_cnt_q;
  logic [WORD_W-1:0] shift_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic rb_seen_q;
  logic [CODE_W-1:0] rb_shift_q;

  // Frame select high ends the frame even if the clock has stopped
  assign frame_clr = rst_in | sync_n_in;

  // ----------------------------------------
  // Shift in
  // ----------------------------------------
  // falling edge sampling
  always_ff @(negedge sclk_in or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt_q <= 5'h00;
      shift_q <= '0;
    end
    else if (bit_cnt_q != DONE_CNT)
    begin
      shift_q <= {shift_q[WORD_W-2:0], din_in};
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Word is frozen until the next full word, so the core may read it late
  always_ff @(negedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      word_out <= '0;
      word_toggle_out <= 1'b0;
    end
    else if (!sync_n_in && bit_cnt_q == LAST_BIT)
    begin
      word_out <= {shift_q[WORD_W-2:0], din_in};
      word_toggle_out <= ~word_toggle_out;
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  // rising edge shift out
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
      rb_seen_q <= 1'b0;
      rb_shift_q <= '0;
      dout_out <= 1'b0;
    end
    else
    begin
      rb_s1_q <= rb_toggle_in;
      rb_s2_q <= rb_s1_q;
      if (!sync_n_in && bit_cnt_q == 5'h00 && rb_s2_q != rb_seen_q)
      begin
        rb_seen_q <= rb_s2_q;
        dout_out <= rb_word_in[CODE_W-1];
        rb_shift_q <= {rb_word_in[CODE_W-2:0], 1'b0};
      end
      else if (!sync_n_in)
      begin
        dout_out <= rb_shift_q[CODE_W-1];
        rb_shift_q <= {rb_shift_q[CODE_W-2:0], 1'b0};
      end
    end
  end
endmodule

// *** src/dhi_top.sv ***
// Host-interface control of a 32-channel converter with sample-and-hold.
// Assumes pins are asynchronous to clk_in and the serial clock is the host's.
//
// Function
// - Parallel mode decodes five address pins, top pin as MSB.
// - In parallel mode the simultaneous-acquire input samples the analog input on all 32 channels.
// - Shared select pin is chip select in parallel, frame sync in serial.
// - Offset select high steers a parallel access to the offset channel.
// - Serial input bits are sampled on the falling serial clock edge.
// - Readback bits leave on rising edge; host takes them on falling.
// - Interface strap low selects parallel, high serial; default parallel.
// - Busy goes low during acquisition and high once it completes.
// - With track high, addressing a channel acquires its analog input.
// - With track low, the analog input bypasses to the output stage.
// - Track rising edge starts acquisition on the addressed channel.
// - Low track pulse of 90 to 200 ns resets the code registers, acquisition and strap; the serial link and readback word keep theirs.
// - Floating address and track read high; acquire and write read low.
// - Reset clears every channel code register, offset channel included.
`timescale 1ns/10ps
`include "dhi_cfg.svh"
module dhi_top #(
  parameter int ADDR_W = `DHI_ADDR_W,
  parameter int CODE_W = `DHI_CODE_W,
  parameter int WORD_W = `DHI_WORD_W,
  parameter int ACQ_CYCLES = `DHI_ACQ_CYC
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] channel_address_in,
  input wire logic sim_acquire_in,
  input wire logic cs_sync_n_in,
  input wire logic wr_n_in,
  input wire logic offset_sel_in,
  input wire logic interface_select_in,
  input wire logic sample_hold_mode_in,
  input wire logic track_in,
  input wire logic [CODE_W-1:0] par_data_in,
  input wire logic [CODE_W-1:0] analog_sample_input_in,
  input wire logic sclk_in,
  input wire logic din_in,
  output logic dout_out,
  output logic busy_n_out,
  output logic track_bypass_out,
  output logic acq_all_out,
  output logic [`DHI_IDX_W-1:0] acq_channel_out,
  output logic code_write_out,
  output logic [`DHI_IDX_W-1:0] code_channel_out,
  output logic [CODE_W-1:0] code_data_out,
  output logic serial_mode_out,
  output logic device_reset_out
);
  localparam int NPIN = ADDR_W + 7;
  localparam int NREG = `DHI_NUM_CH + 1;
  localparam logic [5:0] RST_MIN = 6'(`DHI_RST_MIN_CYC);
  localparam logic [5:0] RST_MAX = 6'(`DHI_RST_MAX_CYC);
  localparam logic [5:0] CNT_SAT = 6'h3F;
  localparam logic [11:0] ACQ_LAST = 12'(ACQ_CYCLES - 1);
  localparam logic [NPIN-1:0] PIN_RST = {{ADDR_W{`DHI_ADDR_RST}}, `DHI_CAL_RST, `DHI_CS_RST,
    `DHI_WR_RST, `DHI_OSEL_RST, `DHI_IFSEL_RST, `DHI_SHM_RST, `DHI_TRACK_RST};

  // Channel index of an access; the offset channel sits above the 32
  function automatic dhi_pkg::dhi_idx_type chan_idx(input logic offset, input logic [ADDR_W-1:0] addr);
    chan_idx = offset ? `DHI_OFFSET_CH : {1'b0, addr};
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [CODE_W-1:0] data_s1_q;
  logic [CODE_W-1:0] data_s2_q;
  logic [CODE_W-1:0] ain_s1_q;
  logic [CODE_W-1:0] ain_s2_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      data_s1_q <= `DHI_CODE_RST;
      data_s2_q <= `DHI_CODE_RST;
      ain_s1_q <= `DHI_CODE_RST;
      ain_s2_q <= `DHI_CODE_RST;
    end
    else if (clk_en_in)
    begin
      pin_s1_q <= {channel_address_in, sim_acquire_in, cs_sync_n_in, wr_n_in,
                   offset_sel_in, interface_select_in, sample_hold_mode_in, track_in};
      pin_s2_q <= pin_s1_q;
      data_s1_q <= par_data_in;
      data_s2_q <= data_s1_q;
      ain_s1_q <= analog_sample_input_in;
      ain_s2_q <= ain_s1_q;
    end
  end

  logic [ADDR_W-1:0] addr_s;
  logic cal_s;
  logic cs_n_s;
  logic wr_n_s;
  logic osel_s;
  logic ifsel_s;
  logic shm_s;
  logic track_s;
  assign {addr_s, cal_s, cs_n_s, wr_n_s, osel_s, ifsel_s, shm_s, track_s} = pin_s2_q;

  // ----------------------------------------
  // Track pulse timer
  // ----------------------------------------
  logic track_prev_q;
  logic [5:0] low_cnt_q;
  logic track_rise;
  logic dev_reset;
  logic track_start;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      track_prev_q <= 1'b1;
      low_cnt_q <= 6'h00;
    end
    else if (clk_en_in)
    begin
      track_prev_q <= track_s;
      if (track_s)
        low_cnt_q <= 6'h00;
      else if (low_cnt_q != CNT_SAT)
        low_cnt_q <= low_cnt_q + 6'h01;
    end
  end

  assign track_rise = track_s & ~track_prev_q;
  assign dev_reset = track_rise && low_cnt_q >= RST_MIN && low_cnt_q <= RST_MAX;
  assign track_start = track_rise && !dev_reset;

  // ----------------------------------------
  // Interface strap
  // ----------------------------------------
  logic serial_q;
  logic strap_taken_q;
  logic [1:0] fill_q;

  // Synchronisers show their reset levels for two edges, so the strap waits for real pin values
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      fill_q <= 2'h0;
    else if (clk_en_in && fill_q != 2'h2)
      fill_q <= fill_q + 2'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      serial_q <= 1'b0;
      strap_taken_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (dev_reset)
        strap_taken_q <= 1'b0;
      else if (!strap_taken_q && fill_q == 2'h2)
      begin
        serial_q <= ifsel_s;
        strap_taken_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Parallel access
  // ----------------------------------------
  logic par_sel_q;
  logic cal_prev_q;
  logic par_sel;
  logic par_write;
  logic cal_rise;

  assign par_sel = !serial_q && strap_taken_q && !cs_n_s && !wr_n_s;
  assign par_write = par_sel && !par_sel_q;
  assign cal_rise = !serial_q && strap_taken_q && cal_s && !cal_prev_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      par_sel_q <= 1'b0;
      cal_prev_q <= `DHI_CAL_RST;
    end
    else if (clk_en_in)
    begin
      par_sel_q <= par_sel;
      cal_prev_q <= cal_s;
    end
  end

  // ----------------------------------------
  // Serial word crossing
  // ----------------------------------------
  logic [WORD_W-1:0] link_word;
  logic link_toggle;
  logic wt_s1_q;
  logic wt_s2_q;
  logic wt_s3_q;
  logic ser_word;
  logic ser_read;
  logic ser_write;
  logic rb_toggle_q;
  logic [CODE_W-1:0] rb_word_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wt_s1_q <= 1'b0;
      wt_s2_q <= 1'b0;
      wt_s3_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      wt_s1_q <= link_toggle;
      wt_s2_q <= wt_s1_q;
      wt_s3_q <= wt_s2_q;
    end
  end

  assign ser_word = serial_q && strap_taken_q && (wt_s2_q ^ wt_s3_q);
  assign ser_read = ser_word && link_word[`DHI_RD_BIT];
  assign ser_write = ser_word && !link_word[`DHI_RD_BIT];

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  logic addr_event;
  dhi_pkg::dhi_idx_type addr_idx;
  logic [CODE_W-1:0] addr_code;

  always_comb
  begin
    addr_event = par_write | ser_write;
    if (ser_write)
    begin
      addr_idx = chan_idx(1'b0, link_word[`DHI_WADDR_MSB:`DHI_WADDR_LSB]);
      addr_code = link_word[CODE_W-1:0];
    end
    else
    begin
      addr_idx = chan_idx(osel_s, addr_s);
      addr_code = data_s2_q;
    end
  end

  // ----------------------------------------
  // Acquisition
  // ----------------------------------------
  dhi_pkg::dhi_acq_state_type state_q;
  dhi_pkg::dhi_idx_type pend_idx_q;
  dhi_pkg::dhi_idx_type acq_idx_q;
  logic acq_all_q;
  logic [11:0] acq_cnt_q;
  logic acq_req;
  logic acq_req_all;
  dhi_pkg::dhi_idx_type acq_req_idx;
  logic acq_done;

  always_comb
  begin
    acq_req = 1'b0;
    acq_req_all = 1'b0;
    acq_req_idx = pend_idx_q;
    if (cal_rise)
    begin
      acq_req = 1'b1;
      acq_req_all = 1'b1;
    end
    else if (addr_event && shm_s && track_s)
    begin
      acq_req = 1'b1;
      acq_req_idx = addr_idx;
    end
    else if (track_start && shm_s)
      acq_req = 1'b1;
  end

  assign acq_done = state_q == dhi_pkg::DHI_ACQUIRE && acq_cnt_q == ACQ_LAST;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pend_idx_q <= '0;
    else if (clk_en_in)
    begin
      if (dev_reset)
        pend_idx_q <= '0;
      else if (addr_event && shm_s)
        pend_idx_q <= addr_idx;
    end
  end

  // Requests during a running acquisition are dropped, not queued
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= dhi_pkg::DHI_IDLE;
      acq_idx_q <= '0;
      acq_all_q <= 1'b0;
      acq_cnt_q <= 12'h000;
    end
    else if (clk_en_in)
    begin
      if (dev_reset)
        state_q <= dhi_pkg::DHI_IDLE;
      else
      begin
        case (state_q)
          dhi_pkg::DHI_IDLE:
          begin
            if (acq_req)
            begin
              state_q <= dhi_pkg::DHI_ACQUIRE;
              acq_idx_q <= acq_req_idx;
              acq_all_q <= acq_req_all;
              acq_cnt_q <= 12'h000;
            end
          end
          dhi_pkg::DHI_ACQUIRE:
          begin
            if (acq_done)
              state_q <= dhi_pkg::DHI_IDLE;
            else
              acq_cnt_q <= acq_cnt_q + 12'h001;
          end
          default:
            state_q <= dhi_pkg::DHI_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Channel code registers
  // ----------------------------------------
  logic [CODE_W-1:0] code_q [NREG];
  logic code_wr;

  assign code_wr = addr_event && !shm_s;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NREG; i++)
        code_q[i] <= `DHI_CODE_RST;
    end
    else if (clk_en_in)
    begin
      if (dev_reset)
      begin
        for (int i = 0; i < NREG; i++)
          code_q[i] <= `DHI_CODE_RST;
      end
      else if (acq_done && acq_all_q)
      begin
        for (int i = 0; i < `DHI_NUM_CH; i++)
          code_q[i] <= ain_s2_q;
      end
      else if (acq_done)
        code_q[acq_idx_q] <= ain_s2_q;
      else if (code_wr)
        code_q[addr_idx] <= addr_code;
    end
  end

  // Read word held until the next read so the link can take it late
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rb_word_q <= `DHI_CODE_RST;
      rb_toggle_q <= 1'b0;
    end
    else if (clk_en_in && ser_read)
    begin
      rb_word_q <= code_q[chan_idx(1'b0, link_word[`DHI_WADDR_MSB:`DHI_WADDR_LSB])];
      rb_toggle_q <= ~rb_toggle_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_n_out <= 1'b1;
      track_bypass_out <= 1'b0;
      acq_all_out <= 1'b0;
      acq_channel_out <= '0;
      code_write_out <= 1'b0;
      code_channel_out <= '0;
      code_data_out <= `DHI_CODE_RST;
      serial_mode_out <= 1'b0;
      device_reset_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      busy_n_out <= !(state_q == dhi_pkg::DHI_ACQUIRE) || acq_done || dev_reset;
      track_bypass_out <= shm_s && !track_s;
      acq_all_out <= acq_all_q;
      acq_channel_out <= acq_all_q ? `DHI_ALL_CH : acq_idx_q;
      code_write_out <= !dev_reset && (acq_done || code_wr);
      if (acq_done)
      begin
        code_channel_out <= acq_all_q ? `DHI_ALL_CH : acq_idx_q;
        code_data_out <= ain_s2_q;
      end
      else if (code_wr)
      begin
        code_channel_out <= addr_idx;
        code_data_out <= addr_code;
      end
      serial_mode_out <= serial_q;
      device_reset_out <= dev_reset;
    end
  end

  // ----------------------------------------
  // Serial link
  // ----------------------------------------
  // select as frame sync
  dhi_serial_link #(
    .WORD_W(WORD_W),
    .CODE_W(CODE_W)
  ) u_link (
    .sclk_in(sclk_in),
    .rst_in(rst_in),
    .sync_n_in(cs_sync_n_in),
    .din_in(din_in),
    .rb_word_in(rb_word_q),
    .rb_toggle_in(rb_toggle_q),
    .word_out(link_word),
    .word_toggle_out(link_toggle),
    .dout_out(dout_out)
  );
endmodule

// *** tb/dhi_top_properties.sv ***
// Concurrent checks on the outputs of the host-interface block.
// Assumes binding to dhi_top; sees its ports only.
`timescale 1ns/10ps
`include "dhi_cfg.svh"
module dhi_top_properties #(
  parameter int ACQ_CYCLES = 4
)(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic track_in,
  input wire logic busy_n_out,
  input wire logic code_write_out,
  input wire logic [`DHI_IDX_W-1:0] code_channel_out,
  input wire logic acq_all_out,
  input wire logic [`DHI_IDX_W-1:0] acq_channel_out,
  input wire logic serial_mode_out,
  input wire logic device_reset_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Counts busy low time; a stuck busy would pass a pure edge check
  int low_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in || busy_n_out)
      low_q <= 0;
    else
      low_q <= low_q + 1;
  end
  property p_busy_max; !busy_n_out |-> low_q < ACQ_CYCLES - 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy held too long");
  property p_busy_len; $rose(busy_n_out) |-> low_q == ACQ_CYCLES - 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy low time wrong");
  property p_acq_done; $rose(busy_n_out) |-> code_write_out && code_channel_out == acq_channel_out; endproperty
  a_acq_done: assert property (p_acq_done) else $error("acquisition end without store");
  property p_cw_pulse; code_write_out |=> !code_write_out; endproperty
  a_cw_pulse: assert property (p_cw_pulse) else $error("write pulse too long");
  property p_chan_range; code_write_out |-> code_channel_out <= 6'h20 || code_channel_out == 6'h3F; endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel index out of range");
  property p_ser_no_off; code_write_out && serial_mode_out |-> code_channel_out != 6'h20; endproperty
  a_ser_no_off: assert property (p_ser_no_off) else $error("serial reached offset channel");
  property p_all_chan; acq_all_out |-> acq_channel_out == 6'h3F; endproperty
  a_all_chan: assert property (p_all_chan) else $error("acquire-all index wrong");
  property p_rst_pulse; device_reset_out |=> !device_reset_out; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_rst_cause; device_reset_out |-> !$past(track_in, 6); endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset without low track");
  property p_rst_idle; device_reset_out |=> busy_n_out ##1 busy_n_out; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after device reset");
endmodule

// *** tb/dhi_host_model.sv ***
// Serial host model: sends 20-bit frames and captures readback bits.
// Assumes the device samples on falling and shifts on rising serial clock.
`timescale 1ns/10ps
module dhi_host_model #(
  parameter int HALF_NS = 15
)(
  output logic sclk_out,
  output logic sync_n_out,
  output logic din_out,
  input wire logic dout_in
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  // Clock stands low between frames; data line idles at its pull-up level
  initial
  begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    din_out = 1'b1;
  end
  task automatic frame(input logic [19:0] word, output logic [19:0] rx);
  begin
    #7 sync_n_out = 1'b0;
    for (int i = 19; i >= 0; i--)
    begin
      #(HALF_NS) sclk_out = 1'b1;
      din_out = word[i];
      #(HALF_NS) sclk_out = 1'b0;
      rx[i] = dout_in;
    end
    #(HALF_NS) sync_n_out = 1'b1;
    din_out = 1'b1;
    #200;
  end
  endtask
endmodule

// *** tb/dhi_top_tb.sv ***
// Bench of the host-interface block: parallel, acquisition, track, serial.
// Assumes dhi_host_model plays the serial host.
`timescale 1ns/10ps
module dhi_top_tb;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  localparam int ACQ = 4;
  logic clk_in = 0, rst_in = 1, wr_n = 1, osel = 0, strap = 0, shm = 0, track = 1, acq_in = 0;
  logic cs_n;
  logic cs_n_par = 1'b1;
  logic [4:0] addr = 5'h1F;
  logic [13:0] pdata = 14'h0000, ain = 14'h0000;
  logic sclk, sync_n, din, dout, busy_n, bypass, acq_all, cw, ser, dev_rst, hit, seen_cw;
  logic [5:0] acq_ch, cw_ch;
  logic [13:0] cw_data;
  logic [19:0] got;
  int n_fail = 0, num_checks = 0;
  always #4 clk_in = ~clk_in;
  dhi_top #(.ACQ_CYCLES(ACQ)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .channel_address_in(addr), .sim_acquire_in(acq_in), .cs_sync_n_in(cs_n), .wr_n_in(wr_n),
    .offset_sel_in(osel), .interface_select_in(strap), .sample_hold_mode_in(shm), .track_in(track),
    .par_data_in(pdata), .analog_sample_input_in(ain), .sclk_in(sclk), .din_in(din), .dout_out(dout),
    .busy_n_out(busy_n), .track_bypass_out(bypass), .acq_all_out(acq_all), .acq_channel_out(acq_ch),
    .code_write_out(cw), .code_channel_out(cw_ch), .code_data_out(cw_data), .serial_mode_out(ser),
    .device_reset_out(dev_rst));
  dhi_host_model host_u (.sclk_out(sclk), .sync_n_out(sync_n), .din_out(din), .dout_in(dout));
  assign cs_n = strap ? sync_n : cs_n_par;
  task automatic stop_test();
  begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
  begin
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  end
  endtask
  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge clk_in);
  end
  endtask
  task automatic wait_cw(input logic [5:0] ch, input logic [13:0] d);
  begin
    for (int i = 0; i < 400 && cw !== 1'b1; i++)
      @(negedge clk_in);
    chk(cw, 1'b1);
    chk(cw_ch, ch);
    chk(cw_data, d);
  end
  endtask
  task automatic do_reset(input logic s);
  begin
    @(posedge clk_in);
    rst_in <= 1;
    strap <= s;
    cyc(6);
    rst_in <= 0;
    cyc(4);
    // Strap lands on the third edge after release; look once the output has settled
    @(negedge clk_in);
  end
  endtask
  task automatic strobe(input logic [4:0] a, input logic o, input logic [5:0] ch, input logic [13:0] d);
  begin
    @(posedge clk_in);
    addr <= a;
    osel <= o;
    pdata <= d;
    cs_n_par <= 0;
    wr_n <= 0;
    wait_cw(ch, shm ? ain : d);
    @(posedge clk_in);
    cs_n_par <= 1;
    wr_n <= 1;
    cyc(6);
  end
  endtask
  task automatic t_parallel();
  begin
    strobe(5'h13, 1'b0, 6'h13, 14'h1A5C);
    strobe(5'h13, 1'b1, 6'h20, 14'h0F0F);
    strobe(5'h01, 1'b0, 6'h01, 14'h3FFF);
  end
  endtask
  task automatic t_acq_all();
  begin
    @(posedge clk_in);
    ain <= 14'h2222;
    acq_in <= 1;
    for (int i = 0; i < 10 && busy_n !== 1'b0; i++)
      @(negedge clk_in);
    chk(busy_n, 1'b0);
    wait_cw(6'h3F, 14'h2222);
    chk(acq_all, 1'b1);
    chk(busy_n, 1'b1);
    @(posedge clk_in);
    acq_in <= 0;
    cyc(6);
  end
  endtask
  task automatic t_hold();
  begin
    @(posedge clk_in);
    shm <= 1;
    ain <= 14'h1357;
    strobe(5'h07, 1'b0, 6'h07, 14'h0000);
    chk(acq_all, 1'b0);
    ain <= 14'h0ACE;
    track <= 0;
    cyc(6);
    track <= 1;
    wait_cw(6'h07, 14'h0ACE);
    cyc(6);
    track <= 0;
    cyc(20);
    @(negedge clk_in);
    chk(bypass, 1'b1);
    cyc(20);
    track <= 1;
    hit = 0;
    seen_cw = 0;
    // A long low is tracking: the rise acquires but must not reset
    repeat (12)
    begin
      @(negedge clk_in);
      hit = hit | dev_rst;
      seen_cw = seen_cw | cw;
    end
    chk(hit, 1'b0);
    chk(seen_cw, 1'b1);
    chk(bypass, 1'b0);
    @(posedge clk_in);
    shm <= 0;
  end
  endtask
  task automatic read_back(input logic [13:0] e);
  begin
    repeat (3) host_u.frame({1'b1, 5'h0A, 14'h0000}, got);
    chk(got[19:6], e);
  end
  endtask
  task automatic t_serial();
  begin
    do_reset(1'b1);
    chk(ser, 1'b1);
    fork
      host_u.frame({1'b0, 5'h0A, 14'h2B3C}, got);
      wait_cw(6'h0A, 14'h2B3C);
    join
    read_back(14'h2B3C);
    @(posedge clk_in);
    track <= 0;
    cyc(15);
    track <= 1;
    for (int i = 0; i < 10 && dev_rst !== 1'b1; i++)
      @(negedge clk_in);
    chk(dev_rst, 1'b1);
    cyc(6);
    read_back(14'h0000);
  end
  endtask
  initial
  begin
    do_reset(1'b0);
    chk(ser, 1'b0);
    t_parallel();
    t_acq_all();
    t_hold();
    t_serial();
    stop_test();
  end
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule
bind dhi_top dhi_top_properties #(.ACQ_CYCLES(ACQ_CYCLES)) chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .track_in(track_in), .busy_n_out(busy_n_out), .code_write_out(code_write_out),
  .code_channel_out(code_channel_out), .acq_all_out(acq_all_out), .acq_channel_out(acq_channel_out),
  .serial_mode_out(serial_mode_out), .device_reset_out(device_reset_out));
